// File: rtl/instr_exec.sv
// execution unit for a subset of an 8-bit core instruction set
`timescale 1ns/1ps
module instr_exec
  import instr_exec_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic instr_valid_in,
  input wire instr_exec_pkg::instr_s instr_in,
  input wire logic [instr_exec_pkg::DATA_W-1:0] file_rdata_in,
  input wire logic [instr_exec_pkg::LATCH_W-1:0] upper_counter_latch_in,
  output logic [instr_exec_pkg::DATA_W-1:0] acc_out,
  output logic null_flag_out,
  output logic [instr_exec_pkg::PC_W-1:0] pc_out,
  output instr_exec_pkg::file_wr_s file_wr_out,
  output logic squash_out
);
  import instr_exec_pkg::*;

  // ==========================================================
  // state
  logic [DATA_W-1:0] acc, next_acc;
  logic null_flag, next_null_flag;
  logic [PC_W-1:0] pc, next_pc;
  file_wr_s file_wr, next_file_wr;
  logic squash, next_squash;
  logic [DATA_W-1:0] result;
  logic exec;

  // a squashed slot is the forced no-op; it must not retire
  assign exec = instr_valid_in && !squash;

  // ==========================================================
  // next-state computation
  always_comb begin
    next_acc = acc;
    next_null_flag = null_flag;
    next_pc = pc;
    next_file_wr = '0;
    // a pending squash waits for its slot, idle cycles do not use it up
    next_squash = squash && !instr_valid_in;
    result = NULL_VALUE;
    if (instr_valid_in) begin
      next_pc = pc + PC_STEP;
    end
    if (exec) begin
      case (instr_in.op)
        OP_CLEAR_ACCUMULATOR: begin
          next_acc = ACC_RESET;
          next_null_flag = 1'b1;
        end
        OP_DECREMENT_SKIP_IF_NULL, OP_DECREMENT_FILE: begin
          result = file_rdata_in - ONE_VALUE;
        end
        OP_INCREMENT_SKIP_IF_NULL, OP_INCREMENT_FILE: begin
          result = file_rdata_in + ONE_VALUE;
        end
        OP_OR_LITERAL_INTO_ACC: begin
          result = acc | instr_in.immediate[DATA_W-1:0];
          next_acc = result;
          next_null_flag = (result == NULL_VALUE);
        end
        OP_OR_ACC_WITH_FILE: begin
          result = acc | file_rdata_in;
        end
        OP_UNCONDITIONAL_JUMP: begin
          next_pc = {upper_counter_latch_in[LATCH_HI:LATCH_LO], instr_in.immediate};
          next_squash = 1'b1;
        end
        default: begin
          next_acc = acc;
        end
      endcase
      case (instr_in.op)
        OP_DECREMENT_SKIP_IF_NULL, OP_INCREMENT_SKIP_IF_NULL, OP_INCREMENT_FILE,
        OP_OR_ACC_WITH_FILE, OP_DECREMENT_FILE: begin
          if (instr_in.dest_sel == DEST_ACC) begin
            next_acc = result;
          end else begin
            next_file_wr.we = 1'b1;
            next_file_wr.addr = instr_in.file_addr;
            next_file_wr.data = result;
          end
          if (instr_in.op == OP_DECREMENT_SKIP_IF_NULL || instr_in.op == OP_INCREMENT_SKIP_IF_NULL) begin
            next_squash = (result == NULL_VALUE);
          end else begin
            next_null_flag = (result == NULL_VALUE);
          end
        end
        default: begin
          next_file_wr = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc <= ACC_RESET;
      null_flag <= 1'b0;
      pc <= PC_RESET;
      file_wr <= '0;
      squash <= 1'b0;
    end else begin
      acc <= next_acc;
      null_flag <= next_null_flag;
      pc <= next_pc;
      file_wr <= next_file_wr;
      squash <= next_squash;
    end
  end

  assign acc_out = acc;
  assign null_flag_out = null_flag;
  assign pc_out = pc;
  assign file_wr_out = file_wr;
  assign squash_out = squash;

  // ==========================================================
  // assertions
  sequence s_skip_zero;
    instr_valid_in && !squash && (instr_in.op inside {OP_DECREMENT_SKIP_IF_NULL, OP_INCREMENT_SKIP_IF_NULL})
      && result == NULL_VALUE;
  endsequence
  sequence s_jump;
    instr_valid_in && !squash && instr_in.op == OP_UNCONDITIONAL_JUMP;
  endsequence

  property p_clear;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.op == OP_CLEAR_ACCUMULATOR |=> acc == 8'h00 && null_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero accumulator");

  property p_dest_file;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.dest_sel && instr_in.op == OP_INCREMENT_FILE
      |=> file_wr.we && file_wr.data == $past(file_rdata_in) + 8'h01 && acc == $past(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination not written");

  property p_skip;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      s_skip_zero |=> squash && null_flag == $past(null_flag);
  endproperty
  a_skip: assert property (p_skip) else $error("zero result did not squash");

  property p_no_skip;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.op == OP_INCREMENT_SKIP_IF_NULL && result != NULL_VALUE |=> !squash;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero result squashed");

  property p_jump_pc;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      s_jump |=> pc == {$past(upper_counter_latch_in[4:3]), $past(instr_in.immediate)} && squash;
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

  property p_squash_idle;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      squash && instr_valid_in |=> acc == $past(acc) && !file_wr.we && null_flag == $past(null_flag);
  endproperty
  a_squash_idle: assert property (p_squash_idle) else $error("squashed slot retired");

  property p_or_lit;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.op == OP_OR_LITERAL_INTO_ACC
      |=> acc == ($past(acc) | $past(instr_in.immediate[7:0])) && null_flag == (acc == 8'h00);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

  property p_dec_acc;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.op == OP_DECREMENT_FILE && !instr_in.dest_sel
      |=> acc == $past(file_rdata_in) - 8'h01 && null_flag == (acc == 8'h00) && !squash;
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement wrong");

  property p_or_file;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.op == OP_OR_ACC_WITH_FILE && !instr_in.dest_sel
      |=> acc == ($past(acc) | $past(file_rdata_in));
  endproperty
  a_or_file: assert property (p_or_file) else $error("or with file wrong");

  property p_inc_flag;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !squash && instr_in.op == OP_INCREMENT_FILE && instr_in.dest_sel
      |=> null_flag == (file_wr.data == 8'h00) && !squash;
  endproperty
  a_inc_flag: assert property (p_inc_flag) else $error("increment flag wrong");

  property p_no_stray_write;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !exec |=> !file_wr.we;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("write without executed slot");

  property p_pc_step;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      instr_valid_in && !(exec && instr_in.op == OP_UNCONDITIONAL_JUMP) |=> pc == $past(pc) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("slot did not advance pc");

  property p_jump_flags;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      s_jump |=> null_flag == $past(null_flag) && acc == $past(acc) && !file_wr.we;
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("jump touched data state");

  // skip, one idle cycle, then the forced no-op slot
  sequence s_squashed_slot;
    squash && instr_valid_in;
  endsequence
  property p_skip_then_nop;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      s_skip_zero ##2 s_squashed_slot |=> !squash && acc == $past(acc);
  endproperty
  a_skip_then_nop: assert property (p_skip_then_nop) else $error("skipped slot not consumed");
endmodule

// File: pkg/instr_exec_pkg.sv
// package: opcodes, operand layout and timing for the instruction execution subset
package instr_exec_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int JUMP_W = 11;
  localparam int LATCH_W = 8;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] NULL_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_VALUE = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int SKIP_CYCLES = 2;
  localparam int JUMP_CYCLES = 2;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_CLEAR_ACCUMULATOR,
    OP_DECREMENT_SKIP_IF_NULL,
    OP_INCREMENT_SKIP_IF_NULL,
    OP_UNCONDITIONAL_JUMP,
    OP_OR_LITERAL_INTO_ACC,
    OP_INCREMENT_FILE,
    OP_OR_ACC_WITH_FILE,
    OP_DECREMENT_FILE
  } op_e;

  typedef struct packed {
    op_e op;
    logic dest_sel;
    logic [FADDR_W-1:0] file_addr;
    logic [JUMP_W-1:0] immediate;
  } instr_s;

  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_s;
endpackage

// File: test/instr_exec_tb_top.sv
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
module instr_exec_tb_top;
  import instr_exec_pkg::*;
  // ==========================================
  // signals and design
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  instr_s instr_in = '0;
  logic [7:0] file_rdata_in = 8'h00;
  logic [7:0] upper_counter_latch_in = 8'h00;
  logic [7:0] acc_out;
  logic null_flag_out;
  logic [12:0] pc_out;
  file_wr_s file_wr_out;
  logic squash_out;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [12:0] exp_pc = 13'h0000;

  instr_exec dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .file_rdata_in(file_rdata_in), .upper_counter_latch_in(upper_counter_latch_in),
    .acc_out(acc_out), .null_flag_out(null_flag_out), .pc_out(pc_out), .file_wr_out(file_wr_out),
    .squash_out(squash_out));

  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // ==========================================
  // shared tasks
  task automatic summarize();
    $display("counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a hundred cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic cmp(logic [15:0] got, logic [15:0] exp, string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one slot, outputs sampled just after the executing edge
  task automatic run(op_e op, logic d, logic [6:0] a, logic [10:0] k, logic [7:0] r);
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= '{op, d, a, k};
    file_rdata_in <= r;
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    #1;
    exp_pc = exp_pc + 13'h0001;
  endtask

  task automatic chk(logic [7:0] a, logic z, logic we, logic [7:0] wd, logic sq);
    cmp(acc_out, a, "acc");
    cmp(null_flag_out, z, "null");
    cmp(file_wr_out.we, we, "write");
    if (we) cmp(file_wr_out.data, wd, "wdata");
    cmp(squash_out, sq, "squash");
    cmp(pc_out, exp_pc, "pc");
  endtask
  // ==========================================
  // scenarios
  task automatic t_or_clear();
    run(OP_OR_LITERAL_INTO_ACC, 0, 7'h00, 11'h05a, 8'h00); chk(8'h5a, 0, 0, 0, 0);
    run(OP_CLEAR_ACCUMULATOR, 0, 7'h00, 11'h000, 8'h00); chk(8'h00, 1, 0, 0, 0);
    run(OP_OR_LITERAL_INTO_ACC, 0, 7'h00, 11'h000, 8'h00); chk(8'h00, 1, 0, 0, 0);
    run(OP_OR_LITERAL_INTO_ACC, 0, 7'h00, 11'h0ff, 8'h00); chk(8'hff, 0, 0, 0, 0);
    $display("test or_clear done");
  endtask

  task automatic t_incdec();
    run(OP_INCREMENT_FILE, 0, 7'h05, 11'h000, 8'hff); chk(8'h00, 1, 0, 0, 0);
    run(OP_INCREMENT_FILE, 1, 7'h7f, 11'h000, 8'h41); chk(8'h00, 0, 1, 8'h42, 0);
    cmp(file_wr_out.addr, 7'h7f, "waddr");
    run(OP_DECREMENT_FILE, 1, 7'h00, 11'h000, 8'h01); chk(8'h00, 1, 1, 8'h00, 0);
    run(OP_DECREMENT_FILE, 0, 7'h03, 11'h000, 8'h00); chk(8'hff, 0, 0, 0, 0);
    run(OP_OR_ACC_WITH_FILE, 1, 7'h09, 11'h000, 8'h00); chk(8'hff, 0, 1, 8'hff, 0);
    run(OP_CLEAR_ACCUMULATOR, 0, 7'h00, 11'h000, 8'h00); chk(8'h00, 1, 0, 0, 0);
    run(OP_OR_ACC_WITH_FILE, 0, 7'h09, 11'h000, 8'h30); chk(8'h30, 0, 0, 0, 0);
    $display("test incdec done");
  endtask

  // null is 0 here, so a zero result that moved the flag would show
  task automatic t_skip();
    run(OP_DECREMENT_SKIP_IF_NULL, 0, 7'h02, 11'h000, 8'h01); chk(8'h00, 0, 0, 0, 1);
    run(OP_OR_LITERAL_INTO_ACC, 0, 7'h00, 11'h0ff, 8'h00); chk(8'h00, 0, 0, 0, 0);
    run(OP_INCREMENT_SKIP_IF_NULL, 1, 7'h04, 11'h000, 8'hff); chk(8'h00, 0, 1, 8'h00, 1);
    run(OP_INCREMENT_FILE, 1, 7'h04, 11'h000, 8'h00); chk(8'h00, 0, 0, 0, 0);
    run(OP_INCREMENT_SKIP_IF_NULL, 0, 7'h04, 11'h000, 8'h10); chk(8'h11, 0, 0, 0, 0);
    run(OP_DECREMENT_SKIP_IF_NULL, 1, 7'h04, 11'h000, 8'h05); chk(8'h11, 0, 1, 8'h04, 0);
    $display("test skip done");
  endtask

  // latch bits outside 4:3 set so a wrong slice is seen
  task automatic t_jump();
    @(posedge sys_clk_in) upper_counter_latch_in <= 8'hef;
    run(OP_UNCONDITIONAL_JUMP, 1, 7'h7f, 11'h2a5, 8'hff);
    exp_pc = {2'b01, 11'h2a5};
    chk(8'h11, 0, 0, 0, 1);
    run(OP_INCREMENT_FILE, 0, 7'h00, 11'h000, 8'h00); chk(8'h11, 0, 0, 0, 0);
    @(posedge sys_clk_in) upper_counter_latch_in <= 8'h10;
    run(OP_UNCONDITIONAL_JUMP, 0, 7'h00, 11'h7ff, 8'h00);
    exp_pc = {2'b10, 11'h7ff};
    chk(8'h11, 0, 0, 0, 1);
    $display("test jump done");
  endtask

  // mid-run reset drops the pending squash and all state
  task automatic t_reset();
    @(posedge sys_clk_in) sys_rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    exp_pc = 13'h0000;
    #1;
    chk(8'h00, 0, 0, 0, 0);
    run(OP_NONE, 1, 7'h11, 11'h7ff, 8'hff); chk(8'h00, 0, 0, 0, 0);
    run(OP_OR_LITERAL_INTO_ACC, 0, 7'h00, 11'h700, 8'h00); chk(8'h00, 1, 0, 0, 0);
    $display("test reset done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_or_clear();
    t_incdec();
    t_skip();
    t_jump();
    t_reset();
    summarize();
  end
endmodule
